// *** core/wcb_pkg.sv ***
package wcb_pkg;
  localparam int                 BEATS_DATA  = 4;
  localparam int                 BEAT_FILL0  = 4;
  localparam int                 BEAT_CRC_LO = 8;
  localparam int                 BEAT_CRC_HI = 9;
  localparam int                 BEAT_W      = 4;
  localparam int                 TREE_W      = 72;
  localparam int                 TREE_LANES  = 8;
  localparam int                 LANE_SPAN   = 8;
  localparam int                 HALF_OFS    = 4;
  localparam int                 MI_BASE     = 64;
  localparam int                 MAX_LANES   = 16;
  localparam int                 X4_LANES    = 4;
  localparam int                 X8_LANES    = 8;
  localparam int                 PAYLOAD_W   = BEATS_DATA * MAX_LANES;
  localparam int                 MI_W        = BEATS_DATA * 2;
  localparam logic [7:0]         CRC_POLY    = 8'h07;
  localparam logic [7:0]         CRC_INIT    = 8'h00;
  localparam logic [7:0]         REG_DATA_LO = 8'h00;
  localparam logic [7:0]         REG_DATA_HI = 8'h04;
  localparam logic [7:0]         REG_MILANE  = 8'h08;
  localparam logic [7:0]         REG_CTRL    = 8'h0C;
  localparam logic [7:0]         REG_STATUS  = 8'h10;
  localparam logic [7:0]         REG_IRQ_MSK = 8'h14;
  localparam logic [7:0]         REG_RESULT  = 8'h18;
  localparam int                 CTRL_START  = 0;
  localparam int                 CTRL_HALF   = 1;
  localparam int                 CTRL_MASK   = 2;
  localparam int                 CTRL_INV    = 3;
  localparam int                 CTRL_INJECT = 4;
  localparam int                 ST_DONE     = 0;
  localparam int                 ST_ALERT    = 1;
  localparam int                 ST_BUSY     = 2;
  localparam int                 EV_W        = 2;
  localparam logic [31:0]        RST_WORD    = 32'h0000_0000;

  typedef logic [BEAT_W-1:0] wcb_beat_t;

  // serial crc, d[71] first, x^8+x^2+x+1, zero start
  function automatic logic [7:0] wcb_crc8(input logic [TREE_W-1:0] d);
    logic [7:0] c;
    logic       fb;
    c = CRC_INIT;
    for (int i = TREE_W - 1; i >= 0; i--)
    begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // q index beat*8+lane; unused tree inputs stay one
  function automatic logic [TREE_W-1:0] wcb_tree_map(input logic [31:0] q,
                                                     input logic [3:0]  mi,
                                                     input logic        mi_on,
                                                     input logic        half,
                                                     input int          lanes);
    logic [TREE_W-1:0] t;
    int                ofs;
    t   = '1;
    ofs = half ? HALF_OFS : 0;
    for (int n = 0; n < TREE_LANES; n++)
    begin
      for (int k = 0; k < BEATS_DATA; k++)
      begin
        if (n < lanes)
        begin
          t[n * LANE_SPAN + k + ofs] = q[k * TREE_LANES + n];
        end
      end
    end
    for (int k = 0; k < BEATS_DATA; k++)
    begin
      if (mi_on)
      begin
        t[MI_BASE + k + ofs] = mi[k];
      end
    end
    return t;
  endfunction
endpackage

// *** core/wcb_link_if.sv ***
interface wcb_link_if #(parameter int LANES = 8);
  logic             wr_act;
  logic [LANES-1:0] dq;
  logic [1:0]       mi;
  logic             half_sel;
  logic             mask_fn_en;
  logic             inv_fn_en;
  logic             alert_n;

  modport ctl (output wr_act, dq, mi, half_sel, mask_fn_en, inv_fn_en, input alert_n);
  modport dev (input wr_act, dq, mi, half_sel, mask_fn_en, inv_fn_en, output alert_n);
endinterface

// *** core/wcb_dram_end.sv ***
// Overview of operation
// - x4: sixteen data inputs, rest forced one
// - beats 4 to 7 carry ones everywhere
// - x4 crc: beat 8 bits 0-3, beat 9 bits 4-7
// - half low: beat k lane n feeds D[8n+k]
// - half high: beats feed upper four of group
// - half high keeps crc beat placement unchanged
// - x8: thirty-six inputs including mask lane
// - x8 crc on beat 8; beat 9 ones
// - x8 half low: D64-67 mask lane or ones
// - x8 half high: D68-71 mask lane or ones
// - x16 has two identical 36-input trees
// - x16 upper tree lanes 8-15, crc 8-15
// - x16 lower tree D64-67 (half high D68-71) mask lane or ones
// - x16 upper tree D136-139 (half high D140-143) mask lane or ones
// - chop fixed; half select picks lower or upper half
// - crc8 over 72 inputs, poly 0 1 2 8
// - crc 7:0 lower inputs, 15:8 upper inputs
module wcb_dram_end
  import wcb_pkg::*;
#(
  parameter int LANES = 8
)
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_i,
  wcb_link_if.dev                   link,
  output logic      [PAYLOAD_W-1:0] wr_data_o,
  output logic      [MI_W-1:0]      wr_mi_o,
  output logic                      wr_valid_o,
  output logic                      crc_error_o,
  output logic      [1:0]           crc_fail_o
);

  if (LANES != X4_LANES && LANES != X8_LANES && LANES != MAX_LANES)
  begin : g_lanes_chk
    $error("LANES must be 4, 8 or 16");
  end

  typedef enum logic [0:0] {
    WCB_IDLE  = 1'b0,
    WCB_BURST = 1'b1
  } wcb_dev_state_e;

  wcb_dev_state_e       state;
  wcb_dev_state_e       next_state;
  wcb_beat_t            cnt;
  wcb_beat_t            next_cnt;
  wcb_beat_t            beat;
  logic [PAYLOAD_W-1:0] qd;
  logic [PAYLOAD_W-1:0] next_qd;
  logic [MI_W-1:0]      mib;
  logic [MI_W-1:0]      next_mib;
  logic                 half;
  logic                 next_half;
  logic [MAX_LANES-1:0] crcr;
  logic [MAX_LANES-1:0] next_crcr;
  logic [PAYLOAD_W-1:0] next_data;
  logic [MI_W-1:0]      next_mi_o;
  logic                 next_valid;
  logic                 next_err;
  logic [1:0]           next_fail;
  logic                 alert_q;
  logic                 next_alert;
  logic [31:0]          qlo;
  logic [31:0]          qhi;
  logic [3:0]           mlo;
  logic [3:0]           mhi;
  logic                 mi_on;
  logic [7:0]           exp_lo;
  logic [7:0]           exp_hi;
  logic [7:0]           rcv_lo;
  logic [7:0]           rcv_hi;

  // split stored beats into per-tree lane groups
  always_comb
  begin
    qlo   = '1;
    qhi   = '1;
    mlo   = '1;
    mhi   = '1;
    mi_on = (link.mask_fn_en || link.inv_fn_en) && (LANES != X4_LANES);
    for (int k = 0; k < BEATS_DATA; k++)
    begin
      for (int n = 0; n < TREE_LANES; n++)
      begin
        qlo[k * TREE_LANES + n] = qd[k * MAX_LANES + n];
        qhi[k * TREE_LANES + n] = qd[k * MAX_LANES + TREE_LANES + n];
      end
      mlo[k] = mib[k * 2];
      mhi[k] = mib[k * 2 + 1];
    end
    // lane masking and half offset inside the map
    exp_lo = wcb_crc8(wcb_tree_map(qlo, mlo, mi_on, half, (LANES < TREE_LANES) ? LANES
                                   : TREE_LANES));
    exp_hi = wcb_crc8(wcb_tree_map(qhi, mhi, mi_on, half, TREE_LANES));
    rcv_hi = crcr[MAX_LANES-1:TREE_LANES];
    if (LANES == X4_LANES)
    begin
      rcv_lo = {link.dq[X4_LANES-1:0], crcr[X4_LANES-1:0]};
    end
    else
    begin
      rcv_lo = crcr[TREE_LANES-1:0];
    end
  end

  // beat capture and check
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_qd    = qd;
    next_mib   = mib;
    next_half  = half;
    next_crcr  = crcr;
    next_data  = wr_data_o;
    next_mi_o  = wr_mi_o;
    next_valid = 1'b0;
    next_err   = 1'b0;
    next_fail  = 2'b00;
    next_alert = 1'b0;
    beat       = (state == WCB_BURST) ? cnt : '0;
    if (link.wr_act)
    begin
      if (beat < BEAT_W'(BEATS_DATA))
      begin
        for (int n = 0; n < LANES; n++)
        begin
          next_qd[beat * MAX_LANES + n] = link.dq[n];
        end
        for (int u = 0; u < 2; u++)
        begin
          next_mib[beat * 2 + u] = link.mi[u];
        end
        if (beat == '0)
        begin
          next_half = link.half_sel;
        end
      end
      // beats 4 to 7 and filler lanes never reach the trees
      if (beat == BEAT_W'(BEAT_CRC_LO))
      begin
        next_crcr = '1;
        for (int n = 0; n < LANES; n++)
        begin
          next_crcr[n] = link.dq[n];
        end
      end
      if (beat == BEAT_W'(BEAT_CRC_HI))
      begin
        next_fail[0] = (exp_lo != rcv_lo);
        next_fail[1] = (LANES == MAX_LANES) && (exp_hi != rcv_hi);
        next_err     = |next_fail;
        next_alert   = |next_fail;
        next_valid   = 1'b1;
        next_data    = qd;
        next_mi_o    = mib;
        next_state   = WCB_IDLE;
        next_cnt     = '0;
      end
      else
      begin
        next_state = WCB_BURST;
        next_cnt   = beat + 1'b1;
      end
    end
    else if (state == WCB_BURST)
    begin
      next_state = WCB_IDLE;
      next_cnt   = '0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state       <= WCB_IDLE;
      cnt         <= '0;
      qd          <= '0;
      mib         <= '0;
      half        <= 1'b0;
      crcr        <= '0;
      wr_data_o   <= '0;
      wr_mi_o     <= '0;
      wr_valid_o  <= 1'b0;
      crc_error_o <= 1'b0;
      crc_fail_o  <= 2'b00;
      alert_q     <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      cnt         <= next_cnt;
      qd          <= next_qd;
      mib         <= next_mib;
      half        <= next_half;
      crcr        <= next_crcr;
      wr_data_o   <= next_data;
      wr_mi_o     <= next_mi_o;
      wr_valid_o  <= next_valid;
      crc_error_o <= next_err;
      crc_fail_o  <= next_fail;
      alert_q     <= next_alert;
    end
  end

  assign link.alert_n = ~alert_q;

endmodule

// *** core/wcb_ctl_end.sv ***
// The address-and-strobe port and the register offsets were left to the implementer.
module wcb_ctl_end
  import wcb_pkg::*;
#(
  parameter int LANES = 8
)
(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             irq_o,
  wcb_link_if.ctl          link
);

  if (LANES != X4_LANES && LANES != X8_LANES && LANES != MAX_LANES)
  begin : g_lanes_chk
    $error("LANES must be 4, 8 or 16");
  end

  typedef enum logic [0:0] {
    WCB_C_IDLE = 1'b0,
    WCB_C_SEND = 1'b1
  } wcb_ctl_state_e;

  wcb_ctl_state_e       state;
  wcb_ctl_state_e       next_state;
  wcb_beat_t            cnt;
  wcb_beat_t            next_cnt;
  logic [PAYLOAD_W-1:0] payload;
  logic [PAYLOAD_W-1:0] next_payload;
  logic [MI_W-1:0]      milane;
  logic [MI_W-1:0]      next_milane;
  logic [3:0]           cfg;
  logic [3:0]           next_cfg;
  logic [EV_W-1:0]      status;
  logic [EV_W-1:0]      next_status;
  logic [EV_W-1:0]      irq_msk;
  logic [EV_W-1:0]      next_irq_msk;
  logic [31:0]          next_rdata;
  logic                 act_q;
  logic                 next_act;
  logic [LANES-1:0]     dq_q;
  logic [LANES-1:0]     next_dq;
  logic [1:0]           mi_q;
  logic [1:0]           next_mi;
  logic [31:0]          qlo;
  logic [31:0]          qhi;
  logic [3:0]           mlo;
  logic [3:0]           mhi;
  logic [7:0]           crc_lo;
  logic [7:0]           crc_hi;
  logic                 mi_on;
  logic                 start;
  logic                 busy;
  logic [EV_W-1:0]      ev;

  assign busy = (state == WCB_C_SEND);

  always_comb
  begin
    qlo = '1;
    qhi = '1;
    mlo = '1;
    mhi = '1;
    for (int k = 0; k < BEATS_DATA; k++)
    begin
      for (int n = 0; n < TREE_LANES; n++)
      begin
        qlo[k * TREE_LANES + n] = payload[k * MAX_LANES + n];
        qhi[k * TREE_LANES + n] = payload[k * MAX_LANES + TREE_LANES + n];
      end
      mlo[k] = milane[k * 2];
      mhi[k] = milane[k * 2 + 1];
    end
    mi_on  = (cfg[CTRL_MASK-1] || cfg[CTRL_INV-1]) && (LANES != X4_LANES);
    crc_lo = wcb_crc8(wcb_tree_map(qlo, mlo, mi_on, cfg[CTRL_HALF-1],
                                   (LANES < TREE_LANES) ? LANES : TREE_LANES));
    crc_hi = wcb_crc8(wcb_tree_map(qhi, mhi, mi_on, cfg[CTRL_HALF-1], TREE_LANES));
    crc_lo[0] = crc_lo[0] ^ cfg[CTRL_INJECT-1];
  end

  // registers, burst sequencing and beat generation
  always_comb
  begin
    next_payload = payload;
    next_milane  = milane;
    next_cfg     = cfg;
    next_irq_msk = irq_msk;
    next_rdata   = RST_WORD;
    next_state   = state;
    next_cnt     = cnt;
    next_act     = 1'b0;
    next_dq      = '1;
    next_mi      = '1;
    start        = 1'b0;
    ev           = '0;
    if (wr_i && !busy)
    begin
      case (addr_i)
        REG_DATA_LO: next_payload[31:0]           = wdata_i;
        REG_DATA_HI: next_payload[PAYLOAD_W-1:32] = wdata_i;
        REG_MILANE:  next_milane                  = wdata_i[MI_W-1:0];
        REG_CTRL:
        begin
          next_cfg = wdata_i[CTRL_INJECT:CTRL_HALF];
          start    = wdata_i[CTRL_START];
        end
        default: ;
      endcase
    end
    if (wr_i && addr_i == REG_IRQ_MSK)
    begin
      next_irq_msk = wdata_i[EV_W-1:0];
    end
    if (rd_i)
    begin
      case (addr_i)
        REG_DATA_LO: next_rdata = payload[31:0];
        REG_DATA_HI: next_rdata = payload[PAYLOAD_W-1:32];
        REG_MILANE:  next_rdata = {{(32 - MI_W){1'b0}}, milane};
        REG_CTRL:    next_rdata = {27'h0000000, cfg, 1'b0};
        REG_STATUS:  next_rdata = {29'h00000000, busy, status};
        REG_IRQ_MSK: next_rdata = {30'h00000000, irq_msk};
        REG_RESULT:  next_rdata = {16'h0000, crc_hi, crc_lo};
        default:     next_rdata = RST_WORD;
      endcase
    end
    if (start || busy)
    begin
      if (start)
      begin
        next_cnt = '0;
      end
      else
      begin
        next_cnt = cnt + 1'b1;
      end
      next_act   = (next_cnt <= BEAT_W'(BEAT_CRC_HI));
      next_state = next_act ? WCB_C_SEND : WCB_C_IDLE;
      ev[ST_DONE] = busy && !next_act;
      if (next_cnt < BEAT_W'(BEATS_DATA))
      begin
        for (int n = 0; n < LANES; n++)
        begin
          next_dq[n] = next_payload[next_cnt * MAX_LANES + n];
        end
        for (int u = 0; u < 2; u++)
        begin
          next_mi[u] = next_milane[next_cnt * 2 + u];
        end
      end
      else if (next_cnt == BEAT_W'(BEAT_CRC_LO))
      begin
        for (int n = 0; n < LANES; n++)
        begin
          next_dq[n] = (n < TREE_LANES) ? crc_lo[n % TREE_LANES] : crc_hi[n % TREE_LANES];
        end
      end
      else if (next_cnt == BEAT_W'(BEAT_CRC_HI) && LANES == X4_LANES)
      begin
        for (int n = 0; n < LANES; n++)
        begin
          next_dq[n] = crc_lo[(n + HALF_OFS) % TREE_LANES];
        end
      end
    end
    ev[ST_ALERT] = !link.alert_n;
    next_status  = ((rd_i && addr_i == REG_STATUS) ? '0 : status) | ev;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state   <= WCB_C_IDLE;
      cnt     <= '0;
      payload <= '0;
      milane  <= '0;
      cfg     <= '0;
      status  <= '0;
      irq_msk <= '0;
      rdata_o <= RST_WORD;
      act_q   <= 1'b0;
      dq_q    <= '1;
      mi_q    <= '1;
    end
    else
    begin
      state   <= next_state;
      cnt     <= next_cnt;
      payload <= next_payload;
      milane  <= next_milane;
      cfg     <= next_cfg;
      status  <= next_status;
      irq_msk <= next_irq_msk;
      rdata_o <= next_rdata;
      act_q   <= next_act;
      dq_q    <= next_dq;
      mi_q    <= next_mi;
    end
  end

  assign irq_o           = |(status & irq_msk);
  assign link.wr_act     = act_q;
  assign link.dq         = dq_q;
  assign link.mi         = mi_q;
  assign link.half_sel   = cfg[CTRL_HALF-1];
  assign link.mask_fn_en = cfg[CTRL_MASK-1];
  assign link.inv_fn_en  = cfg[CTRL_INV-1];

endmodule

// *** test/wcb_tb_pkg.sv ***
package wcb_tb_pkg;
  // expected crc of one tree, eight lanes plus mask lane
  function automatic logic [7:0] exp_crc(input logic [63:0] p, input logic [7:0] m,
                                         input logic h, input logic on, input int t);
    logic [71:0] d;
    logic [7:0]  c;
    d = '1;
    c = 8'h00;
    for (int k = 0; k < 4; k++)
    begin
      for (int n = 0; n < 8; n++)
      begin
        d[8*n+k+4*h] = p[k*16+t*8+n];
      end
      if (on)
      begin
        d[64+k+4*h] = m[k*2+t];
      end
    end
    for (int i = 71; i >= 0; i--)
    begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction
endpackage

// *** test/wcb_link_checker.sv ***
module wcb_link_checker
  import wcb_tb_pkg::*;
#(
  parameter int LANES = 16
)
(
  input wire logic             ref_clk_i,
  input wire logic             reset_i,
  input wire logic             wr_act,
  input wire logic [LANES-1:0] dq,
  input wire logic [1:0]       mi,
  input wire logic             half_sel,
  input wire logic             mask_fn_en,
  input wire logic             inv_fn_en,
  input wire logic             alert_n
);
  logic [3:0]  beat;
  logic [3:0]  next_beat;
  logic [63:0] cap_p;
  logic [63:0] next_cap_p;
  logic [7:0]  cap_m;
  logic [7:0]  next_cap_m;
  logic [15:0] dqw;
  logic        ok;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // beat count and capture of data beats
  always_comb
  begin
    next_beat  = wr_act ? ((beat == 4'h9) ? 4'h0 : beat + 4'h1) : 4'h0;
    next_cap_p = cap_p;
    next_cap_m = cap_m;
    if (wr_act && beat < 4'h4)
    begin
      next_cap_p[int'(beat)*16 +: LANES] = dq;
      next_cap_m[int'(beat)*2 +: 2]      = mi;
    end
    dqw = 16'(dq);
    ok  = (dqw[7:0] == exp_crc(cap_p, cap_m, half_sel, mask_fn_en | inv_fn_en, 0))
       && (LANES < 16 || dqw[15:8] == exp_crc(cap_p, cap_m, half_sel,
                                              mask_fn_en | inv_fn_en, 1));
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      beat  <= 4'h0;
      cap_p <= '1;
      cap_m <= '1;
    end
    else
    begin
      beat  <= next_beat;
      cap_p <= next_cap_p;
      cap_m <= next_cap_m;
    end
  end

  sequence s_ten_beats;
    wr_act [*5] ##1 wr_act [*5];
  endsequence

  sequence s_alert_pulse;
    ##2 !alert_n ##1 alert_n;
  endsequence

  a_fill_beats_ones: assert property (
    wr_act && beat >= 4'h4 && beat <= 4'h7 |-> &dq && &mi)
    else $error("fill beat not all ones");
  a_mask_crc_ones: assert property (
    wr_act && beat >= 4'h8 |-> &mi)
    else $error("mask lane not ones on crc beats");
  a_last_beat_ones: assert property (
    wr_act && beat == 4'h9 && LANES != 4 |-> &dq)
    else $error("beat nine not all ones");
  a_burst_length: assert property (
    $rose(wr_act) |-> s_ten_beats)
    else $error("burst shorter than ten beats");
  a_config_steady: assert property (
    wr_act && $past(wr_act) |-> $stable(half_sel) && $stable(mask_fn_en) && $stable(inv_fn_en))
    else $error("config changed inside burst");
  a_crc_agree: assert property (
    wr_act && beat == 4'h8 && ok |-> ##2 alert_n)
    else $error("alert on matching crc");
  a_crc_mismatch: assert property (
    wr_act && beat == 4'h8 && !ok |-> s_alert_pulse)
    else $error("no single alert pulse on bad crc");
  a_alert_cause: assert property (
    $fell(alert_n) |-> $past(wr_act, 2) && $past(beat, 2) == 4'h8)
    else $error("alert without crc beat");
endmodule

// *** test/write_crc_burst_chop_mapping_tb.sv ***
module write_crc_burst_chop_mapping_tb import wcb_pkg::*, wcb_tb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LANES = 16;
  logic        clk, rst, wr, rd, irq, vld, cerr;
  logic [7:0]  addr, wmi;
  logic [31:0] wdata, rdata, rv;
  logic [1:0]  cfail;
  logic [63:0] wdat;
  int          num_errors, num_checks, cyc;

  wcb_link_if #(.LANES(LANES)) link ();
  wcb_ctl_end #(.LANES(LANES)) wcb_ctl_end_i (.ref_clk_i(clk), .reset_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .link(link.ctl));
  wcb_dram_end #(.LANES(LANES)) wcb_dram_end_i (.ref_clk_i(clk), .reset_i(rst),
    .link(link.dev), .wr_data_o(wdat), .wr_mi_o(wmi), .wr_valid_o(vld), .crc_error_o(cerr),
    .crc_fail_o(cfail));
  wcb_link_checker #(.LANES(LANES)) wcb_link_checker_i (.ref_clk_i(clk), .reset_i(rst),
    .wr_act(link.wr_act), .dq(link.dq), .mi(link.mi), .half_sel(link.half_sel),
    .mask_fn_en(link.mask_fn_en), .inv_fn_en(link.inv_fn_en), .alert_n(link.alert_n));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task results;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      $display("timeout");
      results();
    end
  end

  task check(input string name, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task start(input logic [63:0] p, input logic [7:0] m, input logic [3:0] cfg);
    wr_reg(REG_DATA_LO, p[31:0]);
    wr_reg(REG_DATA_HI, p[63:32]);
    wr_reg(REG_MILANE, {24'h0, m});
    wr_reg(REG_CTRL, {27'h0, cfg, 1'b1});
  endtask

  // wait for the burst, then compare capture and crc
  task fin(input logic [63:0] p, input logic [7:0] m, input logic [3:0] cfg);
    logic [7:0] lo;
    logic [7:0] hi;
    int         i;
    i = 0;
    while (vld !== 1'b1 && i < 40)
    begin
      @(negedge clk);
      i++;
    end
    lo = exp_crc(p, m, cfg[0], cfg[1] | cfg[2], 0) ^ {7'h0, cfg[3]};
    hi = exp_crc(p, m, cfg[0], cfg[1] | cfg[2], 1);
    check("valid", 1, vld);
    check("data", p, wdat);
    check("mask lane", m, wmi);
    check("crc error", cfg[3], cerr);
    check("tree fail", {1'b0, cfg[3]}, cfail);
    rd_reg(REG_RESULT, rv);
    check("result", {hi, lo}, rv[15:0]);
  endtask

  initial
  begin
    rst        = 1'b1;
    wr         = 1'b0;
    rd         = 1'b0;
    addr       = 8'h00;
    wdata      = 32'h0;
    num_errors = 0;
    num_checks = 0;
    cyc        = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_reg(REG_STATUS, rv);
    check("status", 0, rv);
    rd_reg(REG_CTRL, rv);
    check("ctrl", 0, rv);
    rd_reg(8'h1C, rv);
    check("unmapped", 0, rv);
    check("irq", 0, irq);
    $display("test reset done");
    for (int c = 0; c < 8; c++)
    begin
      start(64'hA5C3_0F96_1E2D_3C4B ^ {16{4'(c)}}, 8'h5A ^ 8'(c), 4'(c));
      fin(64'hA5C3_0F96_1E2D_3C4B ^ {16{4'(c)}}, 8'h5A ^ 8'(c), 4'(c));
    end
    start(64'h0, 8'h00, 4'h6);
    fin(64'h0, 8'h00, 4'h6);
    $display("test mapping done");
    rd_reg(REG_STATUS, rv);
    check("status done", 1, rv);
    wr_reg(REG_IRQ_MSK, 32'h2);
    start(64'h0123_4567_89AB_CDEF, 8'hC3, 4'hA);
    fin(64'h0123_4567_89AB_CDEF, 8'hC3, 4'hA);
    check("irq", 1, irq);
    rd_reg(REG_STATUS, rv);
    check("status", 3, rv);
    check("irq", 0, irq);
    $display("test error done");
    wr_reg(REG_IRQ_MSK, 32'h1);
    start(64'hFEDC_BA98_7654_3210, 8'h3C, 4'h1);
    rd_reg(REG_STATUS, rv);
    check("busy", 4, rv);
    wr_reg(REG_DATA_LO, 32'hFFFF_0000);
    fin(64'hFEDC_BA98_7654_3210, 8'h3C, 4'h1);
    check("irq", 1, irq);
    rd_reg(REG_DATA_LO, rv);
    check("busy write dropped", 32'h7654_3210, rv);
    wr_reg(REG_IRQ_MSK, 32'h0);
    @(negedge clk);
    check("irq", 0, irq);
    $display("test busy done");
    results();
  end
endmodule
